/* hw/djtp_debug_port.v */
// Notes on behaviour
// - Pin select level caught after reset picks debug or test-access use of pins.
// - Low test reset clears the test-access logic at once, without clock.
// - Test-access state advances on mode-select sampled at each rising test clock.
// - Test data input is sampled on rising test clock.
// - Test data output enabled only in shift-IR and shift-DR.
// - Test data output updates on falling test clock.
// - Serial debug clock level accepted after two equal system-clock samples.
// - On synchronized serial clock rise, sample input and change serial output.
// - Serial output is registered and lags validation of clock high.
// - Breakpoint with interrupt mode clear halts after current instruction.
// - While halted with trace-quiet clear, state code and trace nibble show 0xF.
// - With interrupt mode set, breakpoint raises a debug interrupt instead.
// - Trace-quiet bit freezes state code and trace nibble and holds trace clock low; triggers stay live.
// - Trace clock idle until first state code of 0xC or above after reset.
// - All-ones output is AND of the four state code bits.
// - Trace clock rises mid-window of valid trace outputs.
// - State code follows core clock and core state, not bus transfers.
// - Trace nibble shows captured data and breakpoint status.
`timescale 1ns/1ps
`default_nettype none
`include "djtp_defines.vh"
module djtp_debug_port #(
  parameter DW = 8
) (
  input  wire          i_clk_sys,
  input  wire          i_resetn,
  input  wire          i_pin_select,
  // Shared pins (test clock / mode / data / reset)
  input  wire          i_pin_clk,
  input  wire          i_pin_tms_breakpoint_request,
  input  wire          i_pin_tdi,
  input  wire          i_pin_trst_serial_debug_clock,
  output reg           o_pin_tdo,
  output reg           o_pin_tdo_oe,
  // Core side
  input  wire [3:0]    i_core_state,
  input  wire [3:0]    i_core_data,
  input  wire          i_instr_done,
  input  wire          i_breakpoint_to_interrupt,
  input  wire          i_trace_clock_quiet,
  input  wire          i_core_resume,
  output reg           o_halted,
  output reg           o_debug_irq,
  // Serial debug bytes: toward the core through the FIFO, from the core straight into the shifter
  output wire          o_rx_valid,
  input  wire          i_rx_ready,
  output wire [DW-1:0] o_rx_data,
  input  wire          i_tx_valid,
  input  wire [DW-1:0] i_tx_data,
  output wire          o_tx_ready,
  // Trace
  output reg  [3:0]    o_processor_state_code,
  output reg  [3:0]    o_trace_data_nibble,
  output reg           o_trace_clock,
  output wire          o_state_code_all_ones,
  output wire          o_serial_debug_out,
  output wire          o_jtag_mode
);
  // ========================================
  // Mode strap
  reg jtag_q;
  reg strap_done_q;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      jtag_q       <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      jtag_q       <= i_pin_select;
      strap_done_q <= 1'b1;
    end
  end
  assign o_jtag_mode = jtag_q;
  // ========================================
  // Test access port, clocked by the pin itself
  wire trst_n = ~(jtag_q & ~i_pin_trst_serial_debug_clock) & i_resetn;
  reg [3:0] tap_q;
  reg [3:0] tap_d;
  reg [3:0] ir_q;
  reg       byp_q;
  always @* begin
    case (tap_q)
      `DJTP_ST_RESET:    tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_RESET : `DJTP_ST_IDLE;
      `DJTP_ST_IDLE:     tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_SEL_DR : `DJTP_ST_IDLE;
      `DJTP_ST_SEL_DR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_SEL_IR : `DJTP_ST_CAP_DR;
      `DJTP_ST_CAP_DR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT1_DR : `DJTP_ST_SHIFT_DR;
      `DJTP_ST_SHIFT_DR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT1_DR : `DJTP_ST_SHIFT_DR;
      `DJTP_ST_EXIT1_DR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_UPD_DR : `DJTP_ST_PAUSE_DR;
      `DJTP_ST_PAUSE_DR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT2_DR : `DJTP_ST_PAUSE_DR;
      `DJTP_ST_EXIT2_DR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_UPD_DR : `DJTP_ST_SHIFT_DR;
      `DJTP_ST_UPD_DR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_SEL_DR : `DJTP_ST_IDLE;
      `DJTP_ST_SEL_IR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_RESET : `DJTP_ST_CAP_IR;
      `DJTP_ST_CAP_IR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT1_IR : `DJTP_ST_SHIFT_IR;
      `DJTP_ST_SHIFT_IR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT1_IR : `DJTP_ST_SHIFT_IR;
      `DJTP_ST_EXIT1_IR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_UPD_IR : `DJTP_ST_PAUSE_IR;
      `DJTP_ST_PAUSE_IR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_EXIT2_IR : `DJTP_ST_PAUSE_IR;
      `DJTP_ST_EXIT2_IR: tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_UPD_IR : `DJTP_ST_SHIFT_IR;
      `DJTP_ST_UPD_IR:   tap_d = i_pin_tms_breakpoint_request ? `DJTP_ST_SEL_DR : `DJTP_ST_IDLE;
      default:           tap_d = `DJTP_ST_RESET;
    endcase
  end
  always @(posedge i_pin_clk or negedge trst_n) begin
    if (!trst_n) begin
      tap_q <= `DJTP_ST_RESET;
      ir_q  <= `DJTP_IR_RESET;
      byp_q <= 1'b0;
    end else if (jtag_q) begin
      tap_q <= tap_d;
      if (tap_q == `DJTP_ST_CAP_IR) begin
        ir_q <= `DJTP_IR_CAPTURE;
      end else if (tap_q == `DJTP_ST_SHIFT_IR) begin
        ir_q <= {i_pin_tdi, ir_q[3:1]};
      end
      if (tap_q == `DJTP_ST_CAP_DR) begin
        byp_q <= 1'b0;
      end else if (tap_q == `DJTP_ST_SHIFT_DR) begin
        byp_q <= i_pin_tdi;
      end
    end
  end
  wire shifting = (tap_q == `DJTP_ST_SHIFT_IR) || (tap_q == `DJTP_ST_SHIFT_DR);
  always @(negedge i_pin_clk or negedge trst_n) begin
    if (!trst_n) begin
      o_pin_tdo    <= 1'b0;
      o_pin_tdo_oe <= 1'b0;
    end else begin
      o_pin_tdo    <= (tap_q == `DJTP_ST_SHIFT_IR) ? ir_q[0] : byp_q;
      o_pin_tdo_oe <= jtag_q & shifting;
    end
  end
  // ========================================
  // Serial debug port, sampled by the system clock
  reg [2:0] sclk_sync_q;
  reg [2:0] breakpoint_request_sync_q;
  reg [1:0] sdi_sync_q;
  reg       sclk_lvl_q;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_sync_q <= 3'h0;
      breakpoint_request_sync_q <= 3'h0;
      sdi_sync_q  <= 2'h0;
      sclk_lvl_q  <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], i_pin_trst_serial_debug_clock};
      breakpoint_request_sync_q <= {breakpoint_request_sync_q[1:0], ~i_pin_tms_breakpoint_request};
      sdi_sync_q  <= {sdi_sync_q[0], i_pin_tdi};
      if (sclk_sync_q[2] == sclk_sync_q[1]) begin
        sclk_lvl_q <= sclk_sync_q[2];
      end
    end
  end
  wire sclk_rise = ~jtag_q & (sclk_sync_q[2] == sclk_sync_q[1]) & sclk_sync_q[2] & ~sclk_lvl_q;
  // Full-duplex byte shifter; MSB first both ways
  reg [DW-1:0] rx_sh_q;
  reg [DW-1:0] tx_sh_q;
  reg [3:0]    bit_q;
  reg          sdo_q;
  reg          rx_push_q;
  wire         rx_in_ready;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_sh_q   <= {DW{1'b0}};
      tx_sh_q   <= {DW{1'b0}};
      bit_q     <= 4'h0;
      sdo_q     <= 1'b0;
      rx_push_q <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      if (sclk_rise) begin
        rx_sh_q <= {rx_sh_q[DW-2:0], sdi_sync_q[1]};
        sdo_q   <= tx_sh_q[DW-1];
        tx_sh_q <= {tx_sh_q[DW-2:0], 1'b0};
        if (bit_q == DW[3:0] - 4'h1) begin
          bit_q     <= 4'h0;
          rx_push_q <= 1'b1;
        end else begin
          bit_q <= bit_q + 4'h1;
        end
      end else if (bit_q == 4'h0 && i_tx_valid && !rx_push_q) begin
        tx_sh_q <= i_tx_data;
      end
    end
  end
  assign o_tx_ready         = (bit_q == 4'h0) && !sclk_rise && !rx_push_q;
  assign o_serial_debug_out = sdo_q;
  // Bytes lost only if the core stalls past a full FIFO of 8
  djtp_fifo #(.WIDTH(DW), .DEPTH(8), .AW(3)) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_in_valid  (rx_push_q),
    .o_in_ready  (rx_in_ready),
    .i_in_data   (rx_sh_q),
    .o_out_valid (o_rx_valid),
    .i_out_ready (i_rx_ready),
    .o_out_data  (o_rx_data)
  );
  // ========================================
  // Breakpoint and halt
  reg breakpoint_request_seen_q;
  reg breakpoint_request_pend_q;
  wire breakpoint_request_rise = ~jtag_q & breakpoint_request_sync_q[2] & ~breakpoint_request_seen_q;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      breakpoint_request_seen_q <= 1'b0;
      breakpoint_request_pend_q <= 1'b0;
      o_halted    <= 1'b0;
      o_debug_irq <= 1'b0;
    end else begin
      breakpoint_request_seen_q <= breakpoint_request_sync_q[2];
      o_debug_irq <= breakpoint_request_rise & i_breakpoint_to_interrupt;
      if (breakpoint_request_rise && !i_breakpoint_to_interrupt) begin
        breakpoint_request_pend_q <= 1'b1;
      end else if (breakpoint_request_pend_q && i_instr_done) begin
        breakpoint_request_pend_q <= 1'b0;
      end
      if (breakpoint_request_pend_q && i_instr_done) begin
        o_halted <= 1'b1;
      end else if (i_core_resume) begin
        o_halted <= 1'b0;
      end
    end
  end
  // ========================================
  // Trace outputs
  reg started_q;
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_processor_state_code <= 4'h0;
      o_trace_data_nibble    <= 4'h0;
      started_q              <= 1'b0;
    end else begin
      if (i_core_state >= `DJTP_PST_EXC) begin
        started_q <= 1'b1;
      end
      if (!i_trace_clock_quiet) begin
        o_processor_state_code <= o_halted ? `DJTP_PST_HALT : i_core_state;
        o_trace_data_nibble    <= o_halted ? `DJTP_PST_HALT
                                           : (breakpoint_request_pend_q ? {3'h0, 1'b1} : i_core_data);
      end
    end
  end
  // Falling-edge toggle puts the rise mid-window of the trace data
  always @(negedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_trace_clock <= 1'b0;
    end else begin
      o_trace_clock <= started_q & ~i_trace_clock_quiet & ~o_trace_clock;
    end
  end
  assign o_state_code_all_ones = &o_processor_state_code;
  wire unused_ok = rx_in_ready;
endmodule // djtp_debug_port
`default_nettype wire

/* hw/djtp_defines.vh */
`ifndef DJTP_DEFINES_VH
`define DJTP_DEFINES_VH
// =====================================
// TAP states
`define DJTP_ST_RESET      4'h0
`define DJTP_ST_IDLE       4'h1
`define DJTP_ST_SEL_DR     4'h2
`define DJTP_ST_CAP_DR     4'h3
`define DJTP_ST_SHIFT_DR   4'h4
`define DJTP_ST_EXIT1_DR   4'h5
`define DJTP_ST_PAUSE_DR   4'h6
`define DJTP_ST_EXIT2_DR   4'h7
`define DJTP_ST_UPD_DR     4'h8
`define DJTP_ST_SEL_IR     4'h9
`define DJTP_ST_CAP_IR     4'hA
`define DJTP_ST_SHIFT_IR   4'hB
`define DJTP_ST_EXIT1_IR   4'hC
`define DJTP_ST_PAUSE_IR   4'hD
`define DJTP_ST_EXIT2_IR   4'hE
`define DJTP_ST_UPD_IR     4'hF
// =====================================
// Trace codes and instruction register values
`define DJTP_PST_HALT      4'hF
`define DJTP_PST_EXC       4'hC
`define DJTP_IR_CAPTURE    4'h1
`define DJTP_IR_RESET      4'h1
`endif

/* hw/djtp_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module djtp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_clk_sys,
  input  wire             i_resetn,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push = i_in_valid && o_in_ready;
  wire            pop  = o_out_valid && i_out_ready;
  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_q];
  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // djtp_fifo
`default_nettype wire

/* hw/unused.v */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/djtp_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module djtp_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  input wire logic       i_pin_trst_serial_debug_clock,
  input wire logic       i_breakpoint_to_interrupt,
  input wire logic       i_trace_clock_quiet,
  input wire logic       i_core_resume,
  input wire logic       i_tx_valid,
  input wire logic       o_halted,
  input wire logic       o_debug_irq,
  input wire logic       o_pin_tdo_oe,
  input wire logic       o_jtag_mode,
  input wire logic       o_trace_clock,
  input wire logic       o_serial_debug_out,
  input wire logic       o_state_code_all_ones,
  input wire logic [3:0] o_processor_state_code,
  input wire logic [3:0] o_trace_data_nibble
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // =====================================
  // Halt, interrupt, trace, pin mode and serial output
  sequence s_halt_entry; $rose(o_halted); endsequence
  sequence s_in_halt; o_halted && $past(o_halted); endsequence
  sequence s_quiet_held; i_trace_clock_quiet [*3]; endsequence
  a_halt_entry_mode: assert property (s_halt_entry |-> !$past(i_breakpoint_to_interrupt))
    else $error("halt taken in interrupt mode");
  a_halt_holds: assert property (o_halted && !i_core_resume |=> o_halted)
    else $error("halt dropped without resume");
  a_halt_code_f: assert property (s_in_halt |-> o_processor_state_code == 4'hF)
    else $error("halt code not all ones");
  a_irq_mode: assert property (o_debug_irq |-> $past(i_breakpoint_to_interrupt) && !o_halted)
    else $error("debug irq outside interrupt mode");
  a_irq_one_cycle: assert property (o_debug_irq |=> !o_debug_irq)
    else $error("debug irq longer than a cycle");
  a_quiet_freeze: assert property (s_quiet_held |-> $stable(o_processor_state_code)
    && $stable(o_trace_data_nibble) && $stable(o_trace_clock))
    else $error("trace moved while quiet");
  a_all_ones_and: assert property (o_state_code_all_ones == &o_processor_state_code)
    else $error("all ones output wrong");
  a_tdo_oe_mode: assert property (o_pin_tdo_oe |-> o_jtag_mode)
    else $error("test output enabled in debug mode");
  // Strap lands on the first edge after release, so two edges of reset-free history are needed
  a_mode_strap: assert property ($past(i_resetn) && $past(i_resetn, 2) |-> $stable(o_jtag_mode))
    else $error("pin mode changed after strap");
  // Tx load only fills the shifter and never sets the line, yet a load still excuses a change
  a_sdo_sync: assert property ($changed(o_serial_debug_out) && !o_jtag_mode |->
    ($past(i_pin_trst_serial_debug_clock) && $past(i_pin_trst_serial_debug_clock, 2)) || $past(i_tx_valid))
    else $error("serial out moved without synced clock");
endmodule // djtp_asserts
bind djtp_debug_port djtp_asserts chk_u (.*);
`default_nettype wire

/* tb/djtp_debug_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module djtp_debug_port_tb;
  logic clk = 0, rst_n = 0, psel = 0, jsel = 0, tck = 0, tms_breakpoint_request = 1, tdi = 1, trst_n = 1;
  logic breakpoint_to_interrupt = 0, quiet = 0, resume = 0, idone = 0, rx_rdy = 0, tx_vld = 0;
  logic [3:0] cstate = 4'h0, cdata = 4'h5;
  logic [7:0] tx_data = 8'h00, got;
  wire h_serial_debug_clock, h_dsi, tdo, oe, halted, irq, rx_vld, tx_rdy, tclk, all1, sdo, jmode;
  wire [7:0] rx_data;
  wire [3:0] code, nib;
  wire pin_d = jsel ? tdi : h_dsi;
  wire pin_c = jsel ? trst_n : h_serial_debug_clock;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  djtp_debug_port dut_u (.i_clk_sys(clk), .i_resetn(rst_n), .i_pin_select(psel),
    .i_pin_clk(tck), .i_pin_tms_breakpoint_request(tms_breakpoint_request), .i_pin_tdi(pin_d), .i_pin_trst_serial_debug_clock(pin_c),
    .o_pin_tdo(tdo), .o_pin_tdo_oe(oe), .i_core_state(cstate), .i_core_data(cdata),
    .i_instr_done(idone), .i_breakpoint_to_interrupt(breakpoint_to_interrupt), .i_trace_clock_quiet(quiet),
    .i_core_resume(resume), .o_halted(halted), .o_debug_irq(irq), .o_rx_valid(rx_vld),
    .i_rx_ready(rx_rdy), .o_rx_data(rx_data), .i_tx_valid(tx_vld), .i_tx_data(tx_data),
    .o_tx_ready(tx_rdy), .o_processor_state_code(code), .o_trace_data_nibble(nib),
    .o_trace_clock(tclk), .o_state_code_all_ones(all1), .o_serial_debug_out(sdo),
    .o_jtag_mode(jmode));
  djtp_host_model host_u (.o_serial_debug_clock(h_serial_debug_clock), .o_dsi(h_dsi), .i_sdo(sdo),
    .i_trace_clock(tclk), .i_code(code));
  // =====================================
  // Clock, timeout, report
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic do_reset(input logic sel);
    @(negedge clk) rst_n = 0;
    psel = sel;
    jsel = sel;
    repeat (6) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
  endtask
  task automatic count_tog(output int n);
    logic t;
    n = 0;
    for (int i = 0; i < 20; i++) begin
      t = tclk;
      @(clk) #2 if (tclk !== t) n++;
    end
  endtask
  // =====================================
  // Scenarios
  task automatic t_trace();
    int n;
    count_tog(n);
    chk("trace idle", 8'h00, n);
    @(negedge clk) cstate = 4'hC;
    repeat (4) @(negedge clk);
    count_tog(n);
    chk("trace runs", 8'h01, n > 0);
    chk("state code", 8'h0C, code);
    @(negedge clk) quiet = 1;
    repeat (3) @(negedge clk);
    cstate = 4'hD;
    cdata = 4'hA;
    count_tog(n);
    chk("quiet toggles", 8'h00, n);
    chk("quiet code", 8'h0C, code);
    @(negedge clk) quiet = 0;
    repeat (4) @(negedge clk);
    chk("resumed code", 8'h0D, code);
    chk("host code", 8'h0D, host_u.seen_code);
  endtask
  task automatic t_break();
    logic seen;
    @(negedge clk) tms_breakpoint_request = 0;
    repeat (4) @(negedge clk);
    chk("early halt", 8'h00, halted);
    idone = 1;
    @(negedge clk) idone = 0;
    repeat (3) @(negedge clk);
    chk("halted", 8'h01, halted);
    chk("halt code", 8'h0F, code);
    chk("halt nibble", 8'h0F, nib);
    chk("all ones", 8'h01, all1);
    tms_breakpoint_request = 1;
    resume = 1;
    @(negedge clk) resume = 0;
    breakpoint_to_interrupt = 1;
    repeat (3) @(negedge clk);
    chk("resumed", 8'h00, halted);
    seen = 0;
    tms_breakpoint_request = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk) idone = (i == 3);
      if (irq === 1'b1) seen = 1;
    end
    chk("debug irq", 8'h01, seen);
    chk("no halt", 8'h00, halted);
    tms_breakpoint_request = 1;
    @(negedge clk) breakpoint_to_interrupt = 0;
  endtask
  task automatic t_serial();
    @(negedge clk) tx_vld = 1;
    tx_data = 8'h3C;
    do @(posedge clk); while (tx_rdy !== 1'b1);
    @(negedge clk) tx_vld = 0;
    host_u.xfer(8'hA5, got);
    chk("serial out", 8'h3C, got);
    for (int i = 0; i < 8; i++) host_u.xfer(8'(i), got);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) chk("rx valid", 8'h01, rx_vld);
      chk("rx data", (i == 0) ? 8'hA5 : 8'(i - 1), rx_data);
      rx_rdy = 1;
      @(negedge clk) rx_rdy = 0;
    end
    @(negedge clk) chk("fifo empty", 8'h00, rx_vld);
  endtask
  task automatic jck(input logic m, input logic d);
    tms_breakpoint_request = m;
    tdi = d;
    #40 tck = 1;
    #50 tck = 0;
    #10;
  endtask
  task automatic t_jtag();
    do_reset(1);
    chk("jtag mode", 8'h01, jmode);
    repeat (5) jck(1, 0);
    jck(0, 0); jck(1, 0); jck(1, 0); jck(0, 0); jck(0, 0);
    chk("ir oe", 8'h01, oe);
    chk("ir tdo", 8'h01, tdo);
    for (int i = 0; i < 4; i++) begin
      jck(0, i != 3);
      chk("ir tdo", 8'(i == 3), tdo);
    end
    jck(1, 0);
    chk("exit oe", 8'h00, oe);
    jck(1, 0); jck(1, 0); jck(0, 0); jck(0, 0);
    chk("dr oe", 8'h01, oe);
    trst_n = 0;
    #20 chk("trst oe", 8'h00, oe);
    trst_n = 1;
  endtask
  initial begin
    do_reset(0);
    t_trace();
    $display("trace test done");
    t_break();
    $display("breakpoint test done");
    t_serial();
    $display("serial test done");
    t_jtag();
    $display("jtag test done");
    final_report();
  end
endmodule // djtp_debug_port_tb
`default_nettype wire

/* tb/djtp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module djtp_host_model (
  output logic           o_serial_debug_clock,
  output logic           o_dsi,
  input  wire logic      i_sdo,
  input  wire logic      i_trace_clock,
  input  wire logic [3:0] i_code
);
  logic [3:0] seen_code;
  // Clock stands low between frames; released data sits at its pull-up
  initial begin
    o_serial_debug_clock = 1'b0;
    o_dsi = 1'b1;
  end
  always @(posedge i_trace_clock) seen_code <= i_code;
  // 80 ns period is a quarter of the trace rate
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_dsi = tx[i];
      #40 o_serial_debug_clock = 1'b1;
      #40 rx[i] = i_sdo;
      o_serial_debug_clock = 1'b0;
    end
    o_dsi = 1'b1;
  endtask
endmodule // djtp_host_model
`default_nettype wire
